// ### test_uart_rx_recovery_addr_filter.sv
// Self-checking bench for the receive recovery block
`timescale 1ns/100ps

module test_uart_rx_recovery_addr_filter;
  import urx_pkg::*;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        rxd;
  logic [2:0]  tx_char_size;
  logic [31:0] r;
  logic [2:0]  code;
  int          nb;
  int          bad_count = 0;
  int          n_compared = 0;

  always #5 hclk = ~hclk;

  urx_rx_recovery i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rxd(rxd), .tx_char_size(tx_char_size));
  urx_tx_model i_tx (.hclk(hclk), .rxd(rxd));

  task automatic chk(input logic [31:0] e, input logic [31:0] g, input string what);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel   <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'h1, a, d, v);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'h0, a, 32'h0, v);
    chk(e, v, $sformatf("reg %h", a));
  endtask : rchk

  task automatic conclude;
    $display("Compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude

  initial begin
    #300000;
    bad_count++;
    conclude();
  end

  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    rchk(URX_OFS_CTRL, 32'h0000000C);
    rchk(URX_OFS_STATUS, 32'h0);
    wr(8'h10, 32'hFFFFFFFF);
    rchk(8'h10, 32'h0);
    chk(32'h3, {29'h0, tx_char_size}, "tx_char_size");
    wr(URX_OFS_BAUD, 32'h1);
    // Character size codes 0 to 3, 5 and 7
    for (int i = 0; i < 6; i++) begin
      code = (i < 4) ? 3'(i) : (i == 4) ? URX_SIZE_NINE : 3'h5;
      nb   = (i < 4) ? i + 5 : (i == 4) ? 9 : 8;
      wr(URX_OFS_CTRL, {26'h0, 1'h1, code, 2'h0});
      i_tx.send(9'h15A, nb, 1'h1, 32, 32, 32);
      rchk(URX_OFS_STATUS, (nb == 9) ? 32'h5 : 32'h1);
      rchk(URX_OFS_DATA, 32'h15A & ((32'h1 << nb) - 1) & 32'hFF);
      chk({29'h0, code}, {29'h0, tx_char_size}, "tx_char_size");
    end
    // Nine bit address filtering
    wr(URX_OFS_CTRL, 32'h0000003D);
    i_tx.send(9'h033, 9, 1'h1, 32, 32, 32);
    rchk(URX_OFS_STATUS, 32'h0);
    i_tx.send(9'h1A7, 9, 1'h1, 32, 32, 32);
    rchk(URX_OFS_STATUS, 32'h5);
    rchk(URX_OFS_DATA, 32'hA7);
    chk(32'h7, {29'h0, tx_char_size}, "tx_char_size");
    wr(URX_OFS_CTRL, 32'h0000003C);
    i_tx.send(9'h044, 9, 1'h1, 32, 32, 32);
    rchk(URX_OFS_STATUS, 32'h1);
    rchk(URX_OFS_DATA, 32'h44);
    // Bad stop bit
    wr(URX_OFS_CTRL, 32'h0000002C);
    i_tx.send(9'h081, 8, 1'h0, 32, 32, 32);
    rchk(URX_OFS_STATUS, 32'h3);
    rchk(URX_OFS_DATA, 32'h81);
    rchk(URX_OFS_STATUS, 32'h0);
    // Stop bit as frame type
    wr(URX_OFS_CTRL, 32'h0000002D);
    i_tx.send(9'h011, 8, 1'h0, 32, 32, 32);
    rchk(URX_OFS_STATUS, 32'h0);
    i_tx.send(9'h022, 8, 1'h1, 32, 32, 32);
    rchk(URX_OFS_STATUS, 32'h1);
    rchk(URX_OFS_DATA, 32'h22);
    // Disabling the receiver drops a buffered frame and its error
    wr(URX_OFS_CTRL, 32'h0000002C);
    i_tx.send(9'h055, 8, 1'h0, 32, 32, 32);
    rchk(URX_OFS_STATUS, 32'h3);
    wr(URX_OFS_CTRL, 32'h0000000C);
    rchk(URX_OFS_STATUS, 32'h0);
    // Noise spike, then wait longer than a whole frame
    wr(URX_OFS_CTRL, 32'h0000002C);
    i_tx.pulse(4);
    repeat (400) @(posedge hclk);
    rchk(URX_OFS_STATUS, 32'h0);
    // Double speed
    wr(URX_OFS_CTRL, 32'h0000002E);
    i_tx.send(9'h096, 8, 1'h1, 16, 16, 16);
    rchk(URX_OFS_STATUS, 32'h1);
    rchk(URX_OFS_DATA, 32'h96);
    // Early start after a short stop bit
    wr(URX_OFS_CTRL, 32'h0000002C);
    fork
      begin
        i_tx.send(9'h03C, 8, 1'h1, 32, 20, 0);
        i_tx.send(9'h0C3, 8, 1'h1, 32, 32, 32);
      end
      begin
        r = 32'h0;
        for (int k = 0; k < 300 && r[0] !== 1'h1; k++) ahb(1'h0, URX_OFS_STATUS, 32'h0, r);
        rchk(URX_OFS_DATA, 32'h3C);
      end
    join
    rchk(URX_OFS_STATUS, 32'h1);
    rchk(URX_OFS_DATA, 32'hC3);
    conclude();
  end
endmodule : test_uart_rx_recovery_addr_filter

// ### urx_pkg.sv
// Package and majority voter for the receive recovery block
package urx_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] URX_OFS_CTRL   = 8'h00;
  localparam logic [7:0] URX_OFS_STATUS = 8'h04;
  localparam logic [7:0] URX_OFS_DATA   = 8'h08;
  localparam logic [7:0] URX_OFS_BAUD   = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int URX_CTRL_FILTER  = 0;
  localparam int URX_CTRL_DOUBLE  = 1;
  localparam int URX_CTRL_SIZE_LO = 2;
  localparam int URX_CTRL_RXEN    = 5;
  localparam int URX_STAT_RXC     = 0;
  localparam int URX_STAT_FE      = 1;
  localparam int URX_STAT_NINTH   = 2;

  // ----------------------------------------------------------------
  // Widths, reset values, size codes and data bit counts
  // ----------------------------------------------------------------
  localparam int          URX_DIV_W        = 12;
  localparam int          URX_SAMP_W       = 5;
  localparam logic [2:0]  URX_SIZE_RST     = 3'h3;
  localparam logic [2:0]  URX_SIZE_NINE    = 3'h7;
  localparam logic [3:0]  URX_BITS_MIN     = 4'h5;
  localparam logic [3:0]  URX_BITS_NINE    = 4'h9;
  localparam logic [URX_DIV_W-1:0] URX_DIV_RST = 12'h000;

  // ----------------------------------------------------------------
  // Oversampling: states per bit and first voted sample
  // ----------------------------------------------------------------
  localparam logic [URX_SAMP_W-1:0] URX_S_NORM  = 5'h10;
  localparam logic [URX_SAMP_W-1:0] URX_S_DBL   = 5'h08;
  localparam logic [URX_SAMP_W-1:0] URX_SF_NORM = 5'h08;
  localparam logic [URX_SAMP_W-1:0] URX_SF_DBL  = 5'h04;
  localparam logic [URX_SAMP_W-1:0] URX_SAMP_1  = 5'h01;

  // ----------------------------------------------------------------
  // Receiver states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    URX_IDLE,
    URX_START,
    URX_DATA,
    URX_STOP
  } urx_rx_state_t;

endpackage : urx_pkg

`timescale 1ns/100ps

// ------------------------------------------------------------------
// Two-of-three majority decision
// ------------------------------------------------------------------
module urx_vote (
  // Three samples from the bit centre
  input  wire logic [2:0] samples,
  // Decided level
  output logic            level
);

  always_comb begin
    level = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);
  end

endmodule : urx_vote

// ### urx_rx_recovery.sv
// Receive data recovery with majority voting and address filtering, AHB-Lite registers
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps

module urx_rx_recovery (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial input pin
  input  wire logic        rxd,
  // Shared character size towards the transmitter
  output logic      [2:0]  tx_char_size
);

  import urx_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  rxd_meta;
    logic                  rxd_sync;
    logic [URX_DIV_W-1:0]  div_cnt;
    logic                  tick;
    urx_rx_state_t         st;
    logic [URX_SAMP_W-1:0] samp;
    logic [3:0]            bit_idx;
    logic [8:0]            shreg;
    logic [1:0]            early;
    logic                  filter_en;
    logic                  double_speed;
    logic [2:0]            char_size;
    logic                  rx_en;
    logic [URX_DIV_W-1:0]  baud_divisor;
    logic [8:0]            buf_data;
    logic                  buf_fe;
    logic                  buf_full;
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic [31:0]           hrdata;
    logic                  hreadyout;
  } urx_state_t;

  urx_state_t q, d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] urx_data_bits(input logic [2:0] size);
    if (size == URX_SIZE_NINE) begin
      return URX_BITS_NINE;
    end else if (size > 3'h3) begin
      return URX_BITS_NINE - 4'h1;
    end else begin
      return URX_BITS_MIN + {1'b0, size};
    end
  endfunction : urx_data_bits

  function automatic logic [31:0] urx_word(input logic [URX_DIV_W-1:0] v);
    return {{(32-URX_DIV_W){1'b0}}, v};
  endfunction : urx_word

  // ----------------------------------------------------------------
  // Sample geometry
  // ----------------------------------------------------------------
  logic [URX_SAMP_W-1:0] spb;
  logic [URX_SAMP_W-1:0] sf;
  logic [3:0]            nbits;
  logic                  voted;
  logic                  frame_type;

  always_comb begin
    spb   = q.double_speed ? URX_S_DBL : URX_S_NORM;
    sf    = q.double_speed ? URX_SF_DBL : URX_SF_NORM;
    nbits = urx_data_bits(q.char_size);
  end

  // Third sample is the live one; the first two were kept
  urx_vote u_vote (
    .samples ({q.early, q.rxd_sync}),
    .level   (voted)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic        bus_take;
  logic        pop;
  logic        frame_done;
  logic        store;
  logic [31:0] rd;

  always_comb begin
    d          = q;
    pop        = 1'b0;
    frame_done = 1'b0;
    store      = 1'b0;
    frame_type = 1'b0;
    rd         = 32'h0000_0000;
    bus_take   = hsel & htrans[1] & hready;

    // Pin synchroniser
    d.rxd_meta = rxd;
    d.rxd_sync = q.rxd_meta;

    // Oversampling tick from the baud divisor
    d.tick = 1'b0;
    if (q.div_cnt >= q.baud_divisor) begin
      d.div_cnt = URX_DIV_RST;
      d.tick    = 1'b1;
    end else begin
      d.div_cnt = q.div_cnt + 12'h001;
    end

    // --------------------------------------------------------------
    // Recovery state machine
    // --------------------------------------------------------------
    if (q.tick) begin
      if (q.samp == sf) begin
        d.early[1] = q.rxd_sync;
      end
      if (q.samp == sf + URX_SAMP_1) begin
        d.early[0] = q.rxd_sync;
      end
      case (q.st)
        URX_IDLE: begin
          if (!q.rxd_sync) begin
            d.st   = URX_START;
            d.samp = URX_SAMP_1 + URX_SAMP_1;
          end else begin
            d.samp = URX_SAMP_1;
          end
        end
        URX_START: begin
          d.samp = q.samp + URX_SAMP_1;
          if (q.samp == sf + 5'h02 && voted) begin
            d.st   = URX_IDLE;
            d.samp = URX_SAMP_1;
          end else if (q.samp == spb) begin
            d.st      = URX_DATA;
            d.samp    = URX_SAMP_1;
            d.bit_idx = 4'h0;
            d.shreg   = 9'h000;
          end
        end
        URX_DATA: begin
          d.samp = q.samp + URX_SAMP_1;
          if (q.samp == sf + 5'h02) begin
            d.shreg[q.bit_idx] = voted;
          end
          if (q.samp == spb) begin
            d.samp    = URX_SAMP_1;
            d.bit_idx = q.bit_idx + 4'h1;
            if (q.bit_idx + 4'h1 == nbits) begin
              d.st = URX_STOP;
            end
          end
        end
        URX_STOP: begin
          d.samp = q.samp + URX_SAMP_1;
          if (q.samp == sf + 5'h02) begin
            frame_done = 1'b1;
            d.st       = URX_IDLE;
            d.samp     = URX_SAMP_1;
          end
        end
        default: begin
          d.st = URX_IDLE;
        end
      endcase
    end

    // --------------------------------------------------------------
    // Frame type and address filter
    // --------------------------------------------------------------
    frame_type = (nbits == URX_BITS_NINE) ? q.shreg[8] : voted;
    // Type one is an address, zero is data
    store = frame_done & (~q.filter_en | frame_type);

    // --------------------------------------------------------------
    // AHB-Lite: read data registered in the address phase
    // --------------------------------------------------------------
    d.hreadyout = 1'b1;
    d.wr_pend   = bus_take & hwrite;
    d.wr_addr   = haddr[7:0];
    if (bus_take && !hwrite) begin
      if (haddr[7:0] == URX_OFS_CTRL) begin
        rd[URX_CTRL_FILTER]                  = q.filter_en;
        rd[URX_CTRL_DOUBLE]                  = q.double_speed;
        rd[URX_CTRL_SIZE_LO+2:URX_CTRL_SIZE_LO] = q.char_size;
        rd[URX_CTRL_RXEN]                    = q.rx_en;
      end else if (haddr[7:0] == URX_OFS_STATUS) begin
        rd[URX_STAT_RXC]   = q.buf_full;
        rd[URX_STAT_FE]    = q.buf_fe & q.buf_full;
        rd[URX_STAT_NINTH] = q.buf_data[8] & q.buf_full;
      end else if (haddr[7:0] == URX_OFS_DATA) begin
        rd[7:0] = q.buf_data[7:0];
        pop     = q.buf_full;
      end else if (haddr[7:0] == URX_OFS_BAUD) begin
        rd = urx_word(q.baud_divisor);
      end else begin
        rd = 32'h0000_0000;
      end
    end
    d.hrdata = rd;

    // Writes land in the data phase
    if (q.wr_pend) begin
      if (q.wr_addr == URX_OFS_CTRL) begin
        d.filter_en    = hwdata[URX_CTRL_FILTER];
        d.double_speed = hwdata[URX_CTRL_DOUBLE];
        d.char_size    = hwdata[URX_CTRL_SIZE_LO+2:URX_CTRL_SIZE_LO];
        d.rx_en        = hwdata[URX_CTRL_RXEN];
      end else if (q.wr_addr == URX_OFS_BAUD) begin
        d.baud_divisor = hwdata[URX_DIV_W-1:0];
      end
    end

    // --------------------------------------------------------------
    // Receive holding register; a new frame wins over a read
    // --------------------------------------------------------------
    if (pop) begin
      d.buf_full = 1'b0;
    end
    if (store && (!q.buf_full || pop)) begin
      d.buf_data = q.shreg;
      d.buf_fe   = ~voted;
      d.buf_full = 1'b1;
    end

    // Receiver off: flush and park
    if (!q.rx_en) begin
      d.st       = URX_IDLE;
      d.samp     = URX_SAMP_1;
      d.buf_full = 1'b0;
      d.buf_fe   = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q              <= '0;
      q.rxd_meta     <= 1'b1;
      q.rxd_sync     <= 1'b1;
      q.st           <= URX_IDLE;
      q.samp         <= URX_SAMP_1;
      q.char_size    <= URX_SIZE_RST;
      q.baud_divisor <= URX_DIV_RST;
      q.hreadyout    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_comb begin
    hrdata       = q.hrdata;
    hreadyout    = q.hreadyout;
    hresp        = 1'b0;
    tx_char_size = q.char_size;
  end

endmodule : urx_rx_recovery

// ### urx_rx_recovery_properties.sv
// Bus and shared size checks for the receive recovery block
`timescale 1ns/100ps

module urx_rx_recovery_chk (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus inputs
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Bus outputs
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Shared size
  input wire logic [2:0]  tx_char_size
);
  import urx_pkg::*;
  logic take;
  logic rd;
  logic wdp_q;

  assign take = hsel & htrans[1] & hready;
  assign rd   = take & ~hwrite;

  // Marks the data phase of a control write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdp_q <= 1'h0;
    end else begin
      wdp_q <= take & hwrite & (haddr[7:0] == URX_OFS_CTRL);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_resp_okay: assert property (hresp == 1'h0) else $error("hresp not OKAY");
  chk_ready_up: assert property ($past(hresetn) |-> hreadyout) else $error("hreadyout low");
  chk_size_write: assert property (wdp_q |=> tx_char_size == $past(hwdata[4:2]))
    else $error("size not taken from write");
  chk_size_hold: assert property (!wdp_q |=> $stable(tx_char_size))
    else $error("size changed without write");
  chk_unmapped_zero: assert property (rd && haddr[7:0] > URX_OFS_BAUD |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_ctrl_size: assert property (rd && haddr[7:0] == URX_OFS_CTRL && !wdp_q |=> hrdata[4:2] == tx_char_size)
    else $error("control size differs from shared size");
  chk_data_width: assert property (rd && haddr[7:0] == URX_OFS_DATA |=> hrdata[31:8] == 24'h0)
    else $error("data upper bits set");
  chk_fe_frame: assert property (rd && haddr[7:0] == URX_OFS_STATUS |=> !(hrdata[1] && !hrdata[0]))
    else $error("frame error without frame");
endmodule : urx_rx_recovery_chk

bind urx_rx_recovery urx_rx_recovery_chk i_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .tx_char_size(tx_char_size));

// ### urx_tx_model.sv
// Remote serial transmitter driving the receive pin
`timescale 1ns/100ps

module urx_tx_model (
  // Clock
  input wire logic hclk,
  // Serial line
  output logic     rxd
);
  initial rxd = 1'h1;

  // Frame LSB first; stop level and lengths chosen by the caller
  task automatic send(input logic [8:0] d, input int nb, input logic stop, input int per, input int slen,
                      input int idle);
    @(posedge hclk);
    rxd <= 1'h0;
    repeat (per) @(posedge hclk);
    for (int i = 0; i < nb; i++) begin
      rxd <= d[i];
      repeat (per) @(posedge hclk);
    end
    rxd <= stop;
    repeat (slen) @(posedge hclk);
    rxd <= 1'h1;
    repeat (idle) @(posedge hclk);
  endtask : send

  // Short low spike on an idle line
  task automatic pulse(input int n);
    @(posedge hclk);
    rxd <= 1'h0;
    repeat (n) @(posedge hclk);
    rxd <= 1'h1;
  endtask : pulse
endmodule : urx_tx_model
